// file: design/icir_defs.vh
`ifndef ICIR_DEFS_VH
`define ICIR_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ICIR_TX_EVT_SET 8'h90
`define ICIR_TX_EVT_CLR 8'h94
`define ICIR_TX_MSK_SET 8'h98
`define ICIR_TX_MSK_CLR 8'h9C
`define ICIR_RX_EVT_SET 8'hA0
`define ICIR_RX_EVT_CLR 8'hA4
`define ICIR_RX_MSK_SET 8'hA8
`define ICIR_RX_MSK_CLR 8'hAC
`define ICIR_INIT_BW 8'hB0
`define ICIR_SUM_STAT 8'hC0
`define ICIR_SUM_MASK 8'hC4

// ----------------------------------------
// Field widths, positions and reset values
// ----------------------------------------
`define ICIR_TX_N 8
`define ICIR_RX_N 4
`define ICIR_BW_W 13
`define ICIR_BW_RST 13'h1333
`define ICIR_TX_MSK_RST 8'h00
`define ICIR_RX_MSK_RST 4'h0
`define ICIR_SUM_TX_BIT 6
`define ICIR_SUM_RX_BIT 7

`endif

// file: design/icir_regs.v
`timescale 1ns/1ps
`include "icir_defs.vh"
module icir_regs (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [7:0] tx_ctx_irq_i,
  input wire [3:0] rx_ctx_irq_i,
  input wire global_reset_input_i,
  input wire fundamental_reset_i,
  input wire secondary_reset_input_i,
  input wire bus_reset_i,
  output reg [12:0] bandwidth_csr_o,
  output wire transmit_summary_event_o,
  output wire receive_summary_event_o,
  output wire irq_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  wire [7:0] tx_flag_q;
  wire [7:0] tx_mask_q;
  wire [3:0] rx_flag_q;
  wire [3:0] rx_mask_q;
  reg [12:0] bw_q;
  wire [1:0] sum_stat_q;
  reg [1:0] sum_mask_q;
  wire [7:0] tx_rise;
  wire [3:0] rx_rise;

  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = acc & wb_we_i;
  wire rd = acc & ~wb_we_i;
  // Byte lanes: only lanes 0 and 1 carry stored bits
  wire [31:0] wdat = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ----------------------------------------
  // Context completion edge detect
  // ----------------------------------------
  // A level held high sets its flag once, so software can clear it
  icir_rise_det #(
    .W(8)
  ) icir_rise_det_tx_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lvl_i(tx_ctx_irq_i),
    .rise_o(tx_rise)
  );

  icir_rise_det #(
    .W(4)
  ) icir_rise_det_rx_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lvl_i(rx_ctx_irq_i),
    .rise_o(rx_rise)
  );

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  reg [7:0] tx_set;
  reg [7:0] tx_clr;
  reg [7:0] txm_set;
  reg [7:0] txm_clr;
  reg [3:0] rx_set;
  reg [3:0] rx_clr;
  reg [3:0] rxm_set;
  reg [3:0] rxm_clr;
  reg bw_wr;
  reg smsk_wr;

  // Unmapped offsets raise no strobe, so such writes are dropped
  always @* begin
    tx_set = 8'h00;
    tx_clr = 8'h00;
    txm_set = 8'h00;
    txm_clr = 8'h00;
    rx_set = 4'h0;
    rx_clr = 4'h0;
    rxm_set = 4'h0;
    rxm_clr = 4'h0;
    bw_wr = 1'b0;
    smsk_wr = 1'b0;
    if (wr) begin
      if (wb_adr_i == `ICIR_TX_EVT_SET) begin
        tx_set = wdat[7:0];
      end else if (wb_adr_i == `ICIR_TX_EVT_CLR) begin
        tx_clr = wdat[7:0];
      end else if (wb_adr_i == `ICIR_TX_MSK_SET) begin
        txm_set = wdat[7:0];
      end else if (wb_adr_i == `ICIR_TX_MSK_CLR) begin
        txm_clr = wdat[7:0];
      end else if (wb_adr_i == `ICIR_RX_EVT_SET) begin
        rx_set = wdat[3:0];
      end else if (wb_adr_i == `ICIR_RX_EVT_CLR) begin
        rx_clr = wdat[3:0];
      end else if (wb_adr_i == `ICIR_RX_MSK_SET) begin
        rxm_set = wdat[3:0];
      end else if (wb_adr_i == `ICIR_RX_MSK_CLR) begin
        rxm_clr = wdat[3:0];
      end else if (wb_adr_i == `ICIR_INIT_BW) begin
        bw_wr = 1'b1;
      end else if (wb_adr_i == `ICIR_SUM_MASK) begin
        smsk_wr = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Per-context flags and masks
  // ----------------------------------------
  // Set wins over a clear in the same cycle
  icir_sc_reg #(
    .W(8),
    .RST(8'h00)
  ) icir_sc_reg_txf_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(tx_set | tx_rise),
    .clr_i(tx_clr),
    .q_o(tx_flag_q)
  );

  icir_sc_reg #(
    .W(8),
    .RST(`ICIR_TX_MSK_RST)
  ) icir_sc_reg_txm_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(txm_set),
    .clr_i(txm_clr),
    .q_o(tx_mask_q)
  );

  icir_sc_reg #(
    .W(4),
    .RST(4'h0)
  ) icir_sc_reg_rxf_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(rx_set | rx_rise),
    .clr_i(rx_clr),
    .q_o(rx_flag_q)
  );

  icir_sc_reg #(
    .W(4),
    .RST(`ICIR_RX_MSK_RST)
  ) icir_sc_reg_rxm_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(rxm_set),
    .clr_i(rxm_clr),
    .q_o(rx_mask_q)
  );

  // ----------------------------------------
  // Summary events and interrupt
  // ----------------------------------------
  assign transmit_summary_event_o = |(tx_flag_q & tx_mask_q);
  assign receive_summary_event_o = |(rx_flag_q & rx_mask_q);
  wire [1:0] sum_evt = {receive_summary_event_o, transmit_summary_event_o};
  assign irq_o = |(sum_stat_q & sum_mask_q);

  wire sum_rd = rd && wb_adr_i == `ICIR_SUM_STAT;

  // Read clears, but a new event in the same cycle survives
  icir_sc_reg #(
    .W(2),
    .RST(2'b00)
  ) icir_sc_reg_sum_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(sum_evt),
    .clr_i({2{sum_rd}}),
    .q_o(sum_stat_q)
  );

  // ----------------------------------------
  // Bandwidth field
  // ----------------------------------------
  // Bus reset does not touch the stored value
  always @(posedge clk_i) begin
    if (rst_i) begin
      bw_q <= `ICIR_BW_RST;
    end else if (bw_wr) begin
      if (wb_sel_i[0]) begin
        bw_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        bw_q[12:8] <= wb_dat_i[12:8];
      end
    end
  end

  // ----------------------------------------
  // Summary mask
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sum_mask_q <= 2'b00;
    end else if (smsk_wr && wb_sel_i[0]) begin
      sum_mask_q <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------
  // Bandwidth CSR load
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      bandwidth_csr_o <= `ICIR_BW_RST;
    end else if (global_reset_input_i | fundamental_reset_i |
                 secondary_reset_input_i | bus_reset_i) begin
      bandwidth_csr_o <= bw_q;
    end
  end

  // ----------------------------------------
  // Wishbone slave: one wait-free ack cycle, unmapped reads zero
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h00000000;
      if (rd) begin
        if (wb_adr_i == `ICIR_TX_EVT_SET) begin
          wb_dat_o <= {24'h000000, tx_flag_q};
        end else if (wb_adr_i == `ICIR_TX_EVT_CLR) begin
          wb_dat_o <= {24'h000000, tx_flag_q & tx_mask_q};
        end else if (wb_adr_i == `ICIR_TX_MSK_SET || wb_adr_i == `ICIR_TX_MSK_CLR) begin
          wb_dat_o <= {24'h000000, tx_mask_q};
        end else if (wb_adr_i == `ICIR_RX_EVT_SET) begin
          wb_dat_o <= {28'h0000000, rx_flag_q};
        end else if (wb_adr_i == `ICIR_RX_EVT_CLR) begin
          wb_dat_o <= {28'h0000000, rx_flag_q & rx_mask_q};
        end else if (wb_adr_i == `ICIR_RX_MSK_SET || wb_adr_i == `ICIR_RX_MSK_CLR) begin
          wb_dat_o <= {28'h0000000, rx_mask_q};
        end else if (wb_adr_i == `ICIR_INIT_BW) begin
          wb_dat_o <= {19'h00000, bw_q};
        end else if (wb_adr_i == `ICIR_SUM_STAT) begin
          wb_dat_o <= {24'h000000, sum_stat_q, 6'h00};
        end else if (wb_adr_i == `ICIR_SUM_MASK) begin
          wb_dat_o <= {30'h00000000, sum_mask_q};
        end
      end
    end
  end

endmodule

// ----------------------------------------
// Set/clear register cell
// ----------------------------------------
// Shared by every flag word and the tx and rx mask words so that set priority is uniform
module icir_sc_reg #(
  parameter W = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] set_i,
  input wire [W-1:0] clr_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] val_q;

  assign q_o = val_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      val_q <= RST;
    end else begin
      val_q <= (val_q & ~clr_i) | set_i;
    end
  end

endmodule

// ----------------------------------------
// Rising edge detector
// ----------------------------------------
// Previous level resets low: an input high at release counts as an edge
module icir_rise_det #(
  parameter W = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] lvl_i,
  output wire [W-1:0] rise_o
);

  reg [W-1:0] lvl_q;

  assign rise_o = lvl_i & ~lvl_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= {W{1'b0}};
    end else begin
      lvl_q <= lvl_i;
    end
  end

endmodule

// file: testbench/icir_regs_assertions.sv
`timescale 1ns/1ps
module icir_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire global_reset_input_i,
  input wire fundamental_reset_i,
  input wire secondary_reset_input_i,
  input wire bus_reset_i,
  input wire [12:0] bandwidth_csr_o,
  input wire transmit_summary_event_o,
  input wire receive_summary_event_o,
  input wire irq_o
);
  // ----------------------------------------
  // Bus and register properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd = wb_ack_o & ~wb_we_i;
  wire any_rst = global_reset_input_i | fundamental_reset_i | secondary_reset_input_i | bus_reset_i;
  property p_ack; wb_cyc_i & wb_stb_i & ~wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request without ack");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_tx_rsvd; rd && wb_adr_i inside {8'h90, 8'h94} |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_tx_rsvd: assert property (p_tx_rsvd) else $error("tx event upper bits set");
  property p_tx_msk; rd && wb_adr_i inside {8'h98, 8'h9C} |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_tx_msk: assert property (p_tx_msk) else $error("tx mask upper bits set");
  property p_rx_rsvd; rd && wb_adr_i inside {8'hA0, 8'hA4} |-> wb_dat_o[31:4] == 28'h0; endproperty
  a_rx_rsvd: assert property (p_rx_rsvd) else $error("rx event upper bits set");
  property p_rx_msk; rd && wb_adr_i inside {8'hA8, 8'hAC} |-> wb_dat_o[31:4] == 28'h0; endproperty
  a_rx_msk: assert property (p_rx_msk) else $error("rx mask upper bits set");
  property p_bw_rsvd; rd && wb_adr_i == 8'hB0 |-> wb_dat_o[31:13] == 19'h0; endproperty
  a_bw_rsvd: assert property (p_bw_rsvd) else $error("bandwidth upper bits set");
  property p_csr_hold; !any_rst |=> $stable(bandwidth_csr_o); endproperty
  a_csr_hold: assert property (p_csr_hold) else $error("csr moved without reset");
  property p_irq_cause;
    $rose(irq_o) |-> $past(transmit_summary_event_o | receive_summary_event_o | wb_we_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule

bind icir_regs icir_chk icir_chk_inst (.*);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, bus_reset_i, irq_o;
  logic global_reset_input_i, fundamental_reset_i, secondary_reset_input_i;
  logic transmit_summary_event_o, receive_summary_event_o;
  logic [3:0] wb_sel_i, rx_ctx_irq_i;
  logic [7:0] wb_adr_i, tx_ctx_irq_i;
  logic [12:0] bandwidth_csr_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [72:0] rows [22];
  int err_total, checks_done, i;

  icir_regs icir_regs_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .tx_ctx_irq_i(tx_ctx_irq_i),
    .rx_ctx_irq_i(rx_ctx_irq_i),
    .global_reset_input_i(global_reset_input_i),
    .fundamental_reset_i(fundamental_reset_i),
    .secondary_reset_input_i(secondary_reset_input_i),
    .bus_reset_i(bus_reset_i),
    .bandwidth_csr_o(bandwidth_csr_o),
    .transmit_summary_event_o(transmit_summary_event_o),
    .receive_summary_event_o(receive_summary_event_o),
    .irq_o(irq_o)
  );

  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end

  task tally_and_finish;
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 9);
    if (wb_ack_o !== 1'h1) begin
      err_total++;
      tally_and_finish;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask

  initial begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, bus_reset_i} = 4'h0;
    {global_reset_input_i, fundamental_reset_i, secondary_reset_input_i} = 3'h0;
    {wb_adr_i, wb_dat_i, rx_ctx_irq_i, tx_ctx_irq_i} = 52'h0;
    wb_sel_i = 4'hF;
    err_total = 0;
    checks_done = 0;
    // Write rows ignore the expected field
    rows = '{{1'h0, 8'hB0, 32'h0, 32'h1333}, {1'h0, 8'hA8, 32'h0, 32'h0},
      {1'h1, 8'h98, 32'hFFFFFF81, 32'h0}, {1'h0, 8'h9C, 32'h0, 32'h81},
      {1'h1, 8'h90, 32'hFF, 32'h0}, {1'h0, 8'h94, 32'h0, 32'h81},
      {1'h0, 8'h90, 32'h0, 32'hFF}, {1'h1, 8'h94, 32'h3, 32'h0},
      {1'h0, 8'h90, 32'h0, 32'hFC}, {1'h1, 8'h9C, 32'h1, 32'h0},
      {1'h0, 8'h98, 32'h0, 32'h80}, {1'h1, 8'hA0, 32'hFFFFFFF5, 32'h0},
      {1'h0, 8'hA0, 32'h0, 32'h5}, {1'h1, 8'hA8, 32'h4, 32'h0},
      {1'h0, 8'hA4, 32'h0, 32'h4}, {1'h1, 8'hA4, 32'h0, 32'h0},
      {1'h0, 8'hA0, 32'h0, 32'h5}, {1'h1, 8'hA4, 32'h5, 32'h0},
      {1'h0, 8'hA0, 32'h0, 32'h0}, {1'h1, 8'hB0, 32'hFFFFFFFF, 32'h0},
      {1'h0, 8'hB0, 32'h0, 32'h1FFF}, {1'h0, 8'h00, 32'h0, 32'h0}};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    chk({19'h0, bandwidth_csr_o}, 32'h1333);
    for (i = 0; i < 22; i++) begin
      bus(rows[i][72], rows[i][71:64], rows[i][63:32]);
      if (!rows[i][72]) chk(rd, rows[i][31:0]);
    end
    chk({31'h0, transmit_summary_event_o}, 32'h1);
    // Context completion edges
    rx_ctx_irq_i <= 4'h8;
    tx_ctx_irq_i <= 8'h01;
    @(posedge clk_i);
    bus(1'h0, 8'hA0, 32'h0);
    chk(rd, 32'h8);
    bus(1'h0, 8'h90, 32'h0);
    chk(rd, 32'hFD);
    bus(1'h1, 8'hA8, 32'h8);
    chk({31'h0, receive_summary_event_o}, 32'h1);
    bus(1'h1, 8'hC4, 32'h2);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'h1, 8'hC4, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'h1, 8'hC4, 32'h2);
    bus(1'h1, 8'hA4, 32'h8);
    bus(1'h0, 8'hC0, 32'h0);
    chk(rd, 32'hC0);
    chk({31'h0, irq_o}, 32'h0);
    // Bus reset reloads the csr from the written field
    bus_reset_i <= 1'h1;
    @(posedge clk_i);
    bus_reset_i <= 1'h0;
    @(posedge clk_i);
    chk({19'h0, bandwidth_csr_o}, 32'h1FFF);
    // A level held high does not set its flag again
    bus(1'h1, 8'h94, 32'h1);
    bus(1'h0, 8'h90, 32'h0);
    chk(rd, 32'hFC);
    // Byte lanes gate the field write; every reset kind reloads the csr
    wb_sel_i <= 4'h1;
    bus(1'h1, 8'hB0, 32'h0);
    bus(1'h0, 8'hB0, 32'h0);
    chk(rd, 32'h1F00);
    global_reset_input_i <= 1'h1;
    @(posedge clk_i);
    global_reset_input_i <= 1'h0;
    @(posedge clk_i);
    chk({19'h0, bandwidth_csr_o}, 32'h1F00);
    wb_sel_i <= 4'h2;
    bus(1'h1, 8'hB0, 32'h0);
    fundamental_reset_i <= 1'h1;
    @(posedge clk_i);
    fundamental_reset_i <= 1'h0;
    @(posedge clk_i);
    chk({19'h0, bandwidth_csr_o}, 32'h0);
    wb_sel_i <= 4'hF;
    bus(1'h1, 8'hB0, 32'hABC);
    secondary_reset_input_i <= 1'h1;
    @(posedge clk_i);
    secondary_reset_input_i <= 1'h0;
    @(posedge clk_i);
    chk({19'h0, bandwidth_csr_o}, 32'hABC);
    // Mid-run reset with context inputs still high
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    chk({19'h0, bandwidth_csr_o}, 32'h1333);
    bus(1'h0, 8'h98, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 8'hB0, 32'h0);
    chk(rd, 32'h1333);
    bus(1'h0, 8'hA0, 32'h0);
    chk(rd, 32'h8);
    chk({30'h0, receive_summary_event_o, irq_o}, 32'h0);
    tally_and_finish;
  end
endmodule
